// File: ebct_params.svh
// Offsets, field positions, reset values and timing counts for the bus timing block
`ifndef EBCT_PARAMS_SVH
`define EBCT_PARAMS_SVH
`define EBCT_ADDR_STATUS 6'h30
`define EBCT_IDX_LAT_DLY 4'h0
`define EBCT_IDX_LAT_WID 4'h1
`define EBCT_IDX_GAP_A 4'h2
`define EBCT_IDX_NCMD 4'h3
`define EBCT_IDX_NWAIT 4'h4
`define EBCT_IDX_WIO_WAIT 4'h5
`define EBCT_IDX_WMEM_CMD 4'h6
`define EBCT_IDX_WMEM_WAIT 4'h7
`define EBCT_IDX_ZW_MIN 4'h8
`define EBCT_IDX_GAP_B 4'hB
`define EBCT_IDX_LAST 4'hC
`define EBCT_CFG_RESET {4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h4, 4'h1, 4'h0, 4'h1, 4'h0}
`define EBCT_ST_BUSY 0
`define EBCT_ST_WIDE 1
`define EBCT_ST_ZW_END 2
`define EBCT_ST_EXTENDED 3
`define EBCT_PIN_LATCH 0
`define EBCT_PIN_MEM 1
`define EBCT_PIN_MEMCS 2
`define EBCT_PIN_IOCS 3
`define EBCT_PIN_RDY 4
`define EBCT_PIN_ZW 5
`define EBCT_PCLK_FALL 2'h1
`define EBCT_PCLK_MID 2'h3
`define EBCT_PINS_IDLE 6'h3C
`endif

// File: ebct_pkg.sv
// Types for the expansion bus cycle timing block
package ebct_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DLY, ST_ADDR, ST_WAIT} ebct_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [5:0] paddr;
    logic [31:0] pwdata;
  } ebct_apb_req_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ebct_apb_rsp_s;
  typedef struct packed {
    logic latch_strobe;
    logic cycle_is_mem;
    logic wide_mem_select_n;
    logic wide_io_select_n;
    logic channel_ready;
    logic zero_wait_request_n;
  } ebct_pins_s;
  typedef struct packed {
    logic processor_clock;
    logic bus_latch;
    logic command_n;
    logic cycle_done;
    logic cycle_wide;
  } ebct_bus_out_s;
  typedef struct packed {
    logic [1:0] div;
    logic [5:0] s1;
    logic [5:0] s2;
    logic latch_q;
    ebct_state_e st;
    logic is_mem;
    logic dec;
    logic wide;
    logic [4:0] tcnt;
    logic [4:0] wcnt;
    logic rdy_q;
    logic zw_hit;
    logic bale;
    logic cmd;
    logic done;
    logic zw_end;
    logic extended;
    logic [12:0][3:0] cfg;
    logic [31:0] prdata;
  } ebct_reg_s;
endpackage : ebct_pkg

// File: ebct_core.sv
// Expansion bus cycle timing: latch strobe, command delay and wait-state control
`timescale 1ns/10ps
`include "ebct_params.svh"

// Functional notes
// RULE_01: Sample zero-wait mid wait state, bus cycles only
// RULE_02: Zero-wait ends cycle after minimum waits elapsed
// RULE_03: Wide memory select judged only in memory cycles
// RULE_04: Wide I/O select judged only in I/O cycles
// RULE_05: Sample channel ready at each t-state end
// RULE_06: Adapter holds ready low one t-state early
// RULE_07: Outputs change at processor clock falling edge
// RULE_08: Latch strobe delayed and widened by settings
// RULE_09: Separate command delays for narrow and wide memory
// RULE_10: Three wait settings by cycle type
// RULE_11: High-speed switch: latch delay written last
// RULE_12: Low-speed switch: narrow waits written last
// RULE_13: Recommended settings for sixteen megahertz clock
// RULE_14: Recommended settings for eight megahertz clock
// RULE_15: Early parts: widen latch strobe one clock
// RULE_16: Ready low keeps adding t-states until high
// RULE_17: Otherwise end after exactly programmed wait count
module ebct_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire ebct_pkg::ebct_apb_req_s apb_req,
  output ebct_pkg::ebct_apb_rsp_s apb_rsp,
  // Expansion bus pins
  input wire ebct_pkg::ebct_pins_s pins,
  output ebct_pkg::ebct_bus_out_s bus_out
);
  import ebct_pkg::*;

  ebct_reg_s r;
  ebct_reg_s n;
  logic fall;
  logic mid;
  logic [4:0] tcnt_n;
  logic [4:0] wcnt_n;
  logic [3:0] lim;
  logic [3:0] cmd_dly;
  logic [3:0] dec_at;
  logic [3:0] idx;
  logic mapped;
  logic apb_wr;

  assign idx = apb_req.paddr[5:2];
  assign mapped = (apb_req.paddr == `EBCT_ADDR_STATUS) ||
                  ((apb_req.paddr[1:0] == 2'h0) && (idx <= `EBCT_IDX_LAST) &&
                   (idx != `EBCT_IDX_GAP_A) && (idx != `EBCT_IDX_GAP_B));
  assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign apb_rsp.prdata = r.prdata;

  assign bus_out.processor_clock = !r.div[1];
  assign bus_out.bus_latch = r.bale;
  assign bus_out.command_n = !r.cmd;
  assign bus_out.cycle_done = r.done;
  assign bus_out.cycle_wide = r.wide;

  assign fall = (r.div == `EBCT_PCLK_FALL);
  assign mid = (r.div == `EBCT_PCLK_MID);
  assign tcnt_n = (r.tcnt == 5'h1F) ? r.tcnt : r.tcnt + 5'h01;
  assign wcnt_n = (r.wcnt == 5'h1F) ? r.wcnt : r.wcnt + 5'h01;

  // Wait-state count by cycle type
  always_comb begin
    if (!r.wide) begin
      lim = r.cfg[`EBCT_IDX_NWAIT]; // RULE_10
    end else if (r.is_mem) begin
      lim = r.cfg[`EBCT_IDX_WMEM_WAIT]; // RULE_10
    end else begin
      lim = r.cfg[`EBCT_IDX_WIO_WAIT]; // RULE_10
    end
  end

  // Command delay by cycle width for memory; I/O cycles use the narrow delay
  always_comb begin
    if (r.is_mem && r.wide) begin
      cmd_dly = r.cfg[`EBCT_IDX_WMEM_CMD]; // RULE_09
    end else begin
      cmd_dly = r.cfg[`EBCT_IDX_NCMD]; // RULE_09
    end
  end

  // Memory size is judged at the earlier of wide command fall or strobe fall
  always_comb begin
    if (r.cfg[`EBCT_IDX_WMEM_CMD] < r.cfg[`EBCT_IDX_LAT_WID]) begin
      dec_at = r.cfg[`EBCT_IDX_WMEM_CMD]; // RULE_03
    end else begin
      dec_at = r.cfg[`EBCT_IDX_LAT_WID]; // RULE_03
    end
  end

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.div = r.div + 2'h1;
    n.s1 = {pins.zero_wait_request_n, pins.channel_ready, pins.wide_io_select_n,
            pins.wide_mem_select_n, pins.cycle_is_mem, pins.latch_strobe};
    n.s2 = r.s1;
    // Zero-wait request taken at the middle of a wait state
    if (mid && (r.st == ST_WAIT) && !r.s2[`EBCT_PIN_ZW] &&
        (r.wcnt >= {1'b0, r.cfg[`EBCT_IDX_ZW_MIN]})) begin
      n.zw_hit = 1'b1; // RULE_01 RULE_02
    end
    // Latch strobe, command and width outputs move on the tick where the processor clock falls
    if (fall) begin // RULE_07
      n.rdy_q = r.s2[`EBCT_PIN_RDY]; // RULE_05
      n.latch_q = r.s2[`EBCT_PIN_LATCH];
      if ((r.st == ST_ADDR) || (r.st == ST_WAIT)) begin
        n.tcnt = tcnt_n;
        if (tcnt_n >= {1'b0, r.cfg[`EBCT_IDX_LAT_WID]}) begin
          n.bale = 1'b0; // RULE_08
        end
      end
      case (r.st)
        ST_IDLE: begin
          if (r.s2[`EBCT_PIN_LATCH] && !r.latch_q) begin
            n.is_mem = r.s2[`EBCT_PIN_MEM];
            n.tcnt = 5'h00;
            n.wcnt = 5'h00;
            n.dec = 1'b0;
            n.wide = 1'b0;
            n.zw_hit = 1'b0;
            n.zw_end = 1'b0;
            n.extended = 1'b0;
            n.st = ST_DLY;
          end
        end
        ST_DLY: begin
          if (r.tcnt >= {1'b0, r.cfg[`EBCT_IDX_LAT_DLY]}) begin
            n.bale = 1'b1; // RULE_08
            n.tcnt = 5'h00;
            n.st = ST_ADDR;
          end else begin
            n.tcnt = tcnt_n;
          end
        end
        ST_ADDR: begin
          if (r.is_mem) begin
            if (!r.dec && (tcnt_n >= {1'b0, dec_at})) begin
              n.dec = 1'b1;
              n.wide = !r.s2[`EBCT_PIN_MEMCS]; // RULE_03
            end
            if ((r.dec || n.dec) && (tcnt_n >= {1'b0, n.wide ?
                r.cfg[`EBCT_IDX_WMEM_CMD] : r.cfg[`EBCT_IDX_NCMD]})) begin
              n.cmd = 1'b1; // RULE_09
              n.st = ST_WAIT;
            end
          end else if (tcnt_n >= {1'b0, r.cfg[`EBCT_IDX_NCMD]}) begin
            n.wide = !r.s2[`EBCT_PIN_IOCS]; // RULE_04
            n.cmd = 1'b1; // RULE_09
            n.st = ST_WAIT;
          end
        end
        ST_WAIT: begin
          n.wcnt = wcnt_n;
          if (r.zw_hit || ((wcnt_n > {1'b0, lim}) && r.rdy_q)) begin
            n.cmd = 1'b0; // RULE_17 RULE_02
            n.bale = 1'b0;
            n.done = 1'b1;
            n.zw_end = r.zw_hit;
            n.st = ST_IDLE;
          end else if ((wcnt_n > {1'b0, lim}) && !r.rdy_q) begin
            n.extended = 1'b1; // RULE_16 RULE_06
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    // Register file; status read shows the cycle engine
    if (apb_req.psel && !apb_req.penable) begin
      n.prdata = 32'h0000_0000;
      if (apb_req.paddr == `EBCT_ADDR_STATUS) begin
        n.prdata[`EBCT_ST_BUSY] = (r.st != ST_IDLE);
        n.prdata[`EBCT_ST_WIDE] = r.wide;
        n.prdata[`EBCT_ST_ZW_END] = r.zw_end;
        n.prdata[`EBCT_ST_EXTENDED] = r.extended;
      end else if (mapped) begin
        n.prdata[3:0] = r.cfg[idx];
      end
    end
    if (apb_wr && mapped && (apb_req.paddr != `EBCT_ADDR_STATUS)) begin
      n.cfg[idx] = apb_req.pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.rdy_q <= 1'b1;
      // Synchronisers start at the idle pin levels so no false request follows reset
      r.s1 <= `EBCT_PINS_IDLE;
      r.s2 <= `EBCT_PINS_IDLE;
      r.cfg <= `EBCT_CFG_RESET; // RULE_14
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  zw_sample_mid_a: assert property ($rose(r.zw_hit) |-> $past(r.st) == ST_WAIT && $past(mid)) // RULE_01
    else $error("zero-wait taken outside a wait-state midpoint");
  zw_min_waits_a: assert property ($rose(r.zw_hit) |->
    $past(r.wcnt) >= {1'b0, r.cfg[`EBCT_IDX_ZW_MIN]}) // RULE_02
    else $error("zero-wait taken before minimum waits");
  zw_ends_a: assert property (r.zw_hit && fall && r.st == ST_WAIT |=> r.done && r.zw_end) // RULE_02
    else $error("zero-wait did not end the cycle");
  out_fall_edge_a: assert property (($changed(r.bale) || $changed(r.cmd)) |->
    $past(r.div) == `EBCT_PCLK_FALL) // RULE_07
    else $error("bus output moved off the falling edge");
  bale_after_dly_a: assert property ($rose(r.bale) |->
    $past(r.st) == ST_DLY && $past(r.tcnt) == {1'b0, r.cfg[`EBCT_IDX_LAT_DLY]}) // RULE_08
    else $error("latch strobe start not at programmed delay");
  io_size_a: assert property ($rose(r.cmd) && !r.is_mem |->
    r.wide == !$past(r.s2[`EBCT_PIN_IOCS])) // RULE_04
    else $error("I/O width not taken from select");
  cmd_delay_a: assert property ($rose(r.cmd) |-> r.tcnt >= {1'b0, cmd_dly}) // RULE_09 RULE_03
    else $error("command fell before programmed delay");
  ready_hold_a: assert property (r.st == ST_WAIT && fall && !r.rdy_q && !r.zw_hit |=> !r.done) // RULE_16
    else $error("cycle ended with ready sampled low");
  exact_waits_a: assert property (r.done && !r.zw_end && !r.extended |->
    $past(r.wcnt) == {1'b0, lim}) // RULE_17 RULE_10
    else $error("cycle length differs from wait setting");
  rdy_sample_a: assert property (fall ##1 1'b1 |-> r.rdy_q == $past(r.s2[`EBCT_PIN_RDY])) // RULE_05
    else $error("ready not sampled at t-state end");
  bale_width_a: assert property ($fell(r.bale) && !r.done |->
    r.tcnt >= {1'b0, r.cfg[`EBCT_IDX_LAT_WID]}) // RULE_08
    else $error("latch strobe shorter than programmed width");
  mem_decided_a: assert property (r.st == ST_WAIT && r.is_mem |-> r.dec) // RULE_03
    else $error("memory command without width decision");
  done_pulse_a: assert property (r.done |=> !r.done) // RULE_17
    else $error("cycle end pulse longer than one clock");
  done_release_a: assert property (r.done |-> !r.cmd && r.st == ST_IDLE) // RULE_17
    else $error("command still active at cycle end");
  ready_end_a: assert property (r.done && !r.zw_end |-> $past(r.rdy_q)) // RULE_16
    else $error("cycle ended without a high ready sample");

  zw_end_c: cover property (r.done && r.zw_end);
  extended_c: cover property (r.done && r.extended);
  wide_mem_c: cover property (r.done && r.wide && r.is_mem);
  narrow_io_c: cover property (r.done && !r.wide && !r.is_mem);
  wide_io_c: cover property (r.done && r.wide && !r.is_mem);
endmodule : ebct_core

// File: ebct_adapter.sv
// Adapter board model: width selects, ready stall and zero-wait request
`timescale 1ns/10ps
module ebct_adapter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus side
  input wire logic processor_clock,
  input wire logic command_n,
  // Scenario knobs
  input wire logic mem_n,
  input wire logic io_n,
  input wire logic zw_on,
  input wire logic [3:0] stall,
  // Adapter pins
  output logic wide_mem_select_n,
  output logic wide_io_select_n,
  output logic channel_ready,
  output logic zero_wait_request_n
);
  logic pc_q;
  logic [3:0] n;
  // Selects are static for the whole cycle, so valid before any command
  assign wide_mem_select_n = mem_n;
  assign wide_io_select_n = io_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 1'b1;
      n <= 4'h0;
      channel_ready <= 1'b1;
      zero_wait_request_n <= 1'b1;
    end else begin
      pc_q <= processor_clock;
      if (command_n) n <= 4'h0;
      else if (pc_q && !processor_clock && n != 4'hF) n <= n + 4'h1;
      // Low from command fall, well ahead of the normal end
      channel_ready <= !(!command_n && n < stall);
      zero_wait_request_n <= !(zw_on && !command_n);
    end
  end
endmodule : ebct_adapter

// File: tb.sv
// Self-checking bench for the expansion bus cycle timing block
`timescale 1ns/10ps
module tb;
  import ebct_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ebct_apb_req_s req = '0;
  ebct_apb_rsp_s rsp;
  ebct_pins_s pins;
  ebct_bus_out_s bo;
  logic strobe = 1'b0;
  logic is_mem = 1'b0;
  logic mem_n = 1'b1;
  logic io_n = 1'b1;
  logic zw_on = 1'b0;
  logic [3:0] stall = 4'h0;
  logic exact = 1'b1;
  logic wm_n, wi_n, rdy, zw_n;
  logic cmd_p = 1'b1;
  logic pc_p = 1'b1;
  logic [31:0] q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int n_cmd = 0;
  int n_bale = 0;
  int last_len = 0;
  int ticks = 0;
  int rst[13] = '{0, 1, 0, 1, 4, 1, 0, 1, 0, 0, 0, 0, 0};
  int ord[10] = '{5, 6, 7, 8, 9, 10, 4, 3, 1, 0};
  int val[10] = '{4, 2, 4, 2, 0, 0, 10, 4, 3, 1};
  int ord2[10] = '{5, 6, 7, 8, 9, 10, 0, 1, 3, 4};
  int val2[10] = '{1, 0, 1, 0, 0, 0, 0, 1, 1, 4};
  int tbl[6][5] = '{'{0, 1, 1, 10, 0}, '{0, 1, 0, 4, 1}, '{1, 1, 1, 10, 0},
                    '{1, 1, 0, 10, 0}, '{0, 0, 1, 10, 0}, '{1, 0, 1, 4, 1}};
  always #5 pclk = ~pclk;
  assign pins = '{strobe, is_mem, wm_n, wi_n, rdy, zw_n};
  ebct_core u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .pins(pins), .bus_out(bo));
  ebct_adapter u_adp (.pclk(pclk), .presetn(presetn), .processor_clock(bo.processor_clock),
    .command_n(bo.command_n), .mem_n(mem_n), .io_n(io_n), .zw_on(zw_on), .stall(stall),
    .wide_mem_select_n(wm_n), .wide_io_select_n(wi_n), .channel_ready(rdy),
    .zero_wait_request_n(zw_n));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic err);
    if (!w) q.push_back(e);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    check("pslverr", {31'h0, rsp.pslverr}, {31'h0, err});
    req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic cyc(input logic m, input logic mn, input logic in, input int w,
                     input int wd, input int wide);
    int k;
    k = 0;
    if (exact) begin
      q.push_back(4 * (w + 1));
      q.push_back(4 * wd);
      q.push_back(wide);
    end
    is_mem <= m;
    mem_n <= mn;
    io_n <= in;
    strobe <= 1'b1;
    do begin
      @(negedge pclk);
      k++;
    end while (bo.cycle_done !== 1'b1 && k < 400);
    if (k >= 400) check("done", 0, 1);
    @(posedge pclk);
    strobe <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : cyc
  // Run limit well above the length of all scenarios
  always @(negedge pclk) begin
    ticks++;
    if (ticks == 5000) begin
      error_cnt++;
      results();
    end
  end
  // Outputs are settled at the falling edge
  always @(negedge pclk) begin
    if (req.psel && req.penable) check("pready", {31'h0, rsp.pready}, 32'h1);
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
      check("prdata", rsp.prdata, q.pop_front());
    if (bo.command_n !== cmd_p) check("cmd_edge", {pc_p, bo.processor_clock}, 2'b10);
    cmd_p = bo.command_n;
    pc_p = bo.processor_clock;
    if (bo.cycle_done === 1'b1) begin
      last_len = n_cmd;
      if (exact) begin
        check("cmd_len", n_cmd, q.pop_front());
        check("bale_len", n_bale, q.pop_front());
        check("wide", {31'h0, bo.cycle_wide}, q.pop_front());
      end
      n_cmd = 0;
      n_bale = 0;
    end else begin
      if (bo.command_n === 1'b0) n_cmd++;
      if (bo.bus_latch === 1'b1) n_bale++;
    end
  end
  initial begin
    logic [31:0] d;
    d = $urandom(88);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 13; i++) apb(0, 6'(4 * i), 0, rst[i], i == 2 || i == 11);
    cyc(0, 1, 1, 4, 1, 0);
    for (int i = 0; i < 12; i++) begin
      d = $urandom();
      apb(1, 6'(4 * i), d, 0, i == 2 || i == 11);
      apb(0, 6'(4 * i), 0, (i == 2 || i == 11) ? 0 : d[3:0], i == 2 || i == 11);
    end
    // High-speed set; latch strobe one clock wider since delay plus width reaches 4
    for (int i = 0; i < 10; i++) apb(1, 6'(4 * ord[i]), val[i], 0, 0);
    for (int i = 0; i < 6; i++)
      cyc(tbl[i][0][0], tbl[i][1][0], tbl[i][2][0], tbl[i][3], 3, tbl[i][4]);
    apb(0, 6'h30, 0, 32'h2, 0);
    for (int i = 0; i < 10; i++) apb(1, 6'(4 * ord2[i]), val2[i], 0, 0);
    cyc(0, 1, 1, 4, 1, 0);
    exact = 1'b0;
    apb(1, 6'h10, 6, 0, 0);
    zw_on <= 1'b1;
    cyc(0, 1, 1, 0, 0, 0);
    check("zw_len", last_len < 28, 1);
    apb(1, 6'h20, 3, 0, 0);
    cyc(0, 1, 1, 0, 0, 0);
    check("zw_min", last_len >= 16 && last_len < 28, 1);
    zw_on <= 1'b0;
    apb(0, 6'h30, 0, 32'h4, 0);
    stall <= 4'h9;
    cyc(0, 1, 1, 0, 0, 0);
    check("rdy_len", last_len >= 36, 1);
    apb(0, 6'h30, 0, 32'h8, 0);
    results();
  end
endmodule : tb
